/* File: rtl/wdt_pkg.sv */
// constants, field layout and types of the watchdog and reset-cause block
// assumes one system clock pclk (50 MHz) and an apb master for software access
// Summary of operation
// - watchdog reset sets cause bit 3; cleared by write zero
// - brown-out reset sets cause bit 2; write zero clears
// - external reset sets cause bit 1; write zero clears
// - power-on sets cause bit 0; only write zero clears
// - cause bits 7..4 always read zero
// - time-out in interrupt mode sets flag; vector or one clears
// - interrupt taken only with global and local enable
// - reset and interrupt enables choose the mode
// - combined mode: vector clears enable and flag
// - combined mode: unserved flag plus time-out resets
// - programmed always-on fuse forces reset mode
// - clearing reset enable or period needs change window
// - change window closes four clock cycles after opening
// - reset enable forced set while watchdog cause set
// - period code 0..9 gives 2048 to 1048576 cycles
// - new values written within four cycles, window bit clear
// - restart request clears the watchdog counter
// - time-out reset is a one-cycle pulse
// - counter counts cycles of the separate watchdog oscillator
`default_nettype none

package wdt_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] CTRL_ADDR       = 12'h060;
    localparam logic [11:0] CAUSE_ADDR      = 12'h064;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_IF_BIT  = 7;
    localparam int CTRL_IE_BIT  = 6;
    localparam int CTRL_P3_BIT  = 5;
    localparam int CTRL_CE_BIT  = 4;
    localparam int CTRL_RE_BIT  = 3;
    localparam int CTRL_P2_BIT  = 2;
    localparam int CAUSE_WD_BIT = 3;
    localparam int CAUSE_BO_BIT = 2;
    localparam int CAUSE_EX_BIT = 1;
    localparam int CAUSE_PO_BIT = 0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [3:0] PERIOD_RESET         = 4'h0;
    localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
    localparam logic [4:0] PERIOD_BASE_LOG2     = 5'h0B;
    localparam logic [3:0] PERIOD_MAX_SEL       = 4'h9;
    localparam int         COUNT_W              = 20;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WDT_STOPPED,
        WDT_INT,
        WDT_RST,
        WDT_INT_RST
    } wdt_mode_t;

    typedef struct packed {
        logic brownout;
        logic external_pin;
    } wdt_reset_events_t;

    typedef struct packed {
        logic       timeout_interrupt_flag;
        logic       timeout_interrupt_enable;
        logic [3:0] timeout_period_select;
        logic       timeout_reset_enable;
        logic [2:0] window_count;
        logic       watchdog_reset_cause_flag;
        logic       brownout_cause_flag;
        logic       external_pin_cause_flag;
        logic       power_on_cause_flag;
        logic       sys_reset_pulse;
        logic [7:0] rdata;
    } wdt_state_t;

endpackage

`default_nettype wire

/* File: rtl/wdt_osc_sync.sv */
// synchroniser and rising-edge finder for the watchdog oscillator pin
// assumes the oscillator runs far slower than pclk
`default_nettype none

module wdt_osc_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic osc_in,
    output logic      osc_rise
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } wdt_sync_state_t;

    wdt_sync_state_t s;
    wdt_sync_state_t next_s;

    // ------------------------------------------------------------
    // two-stage synchroniser, edge taken after the second stage
    // ------------------------------------------------------------
    always_comb begin
        next_s      = s;
        next_s.meta = osc_in;
        next_s.sync = s.meta;
        next_s.last = s.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign osc_rise = s.sync & ~s.last;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rise_single_pulse: assert property (osc_rise |=> !osc_rise)
        else $error("oscillator edge pulse longer than one cycle");
    a_rise_follows_pin: assert property (osc_rise |-> $past(osc_in, 2) && !$past(osc_in, 3))
        else $error("oscillator edge without delayed pin high");

endmodule

`default_nettype wire

/* File: rtl/wdt_counter.sv */
// watchdog period counter, advanced by oscillator edges
// assumes tick is a one-cycle pulse per oscillator period
`default_nettype none

module wdt_counter #(
    parameter int COUNT_W = wdt_pkg::COUNT_W
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [3:0] period_select,
    output logic            timeout
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               timeout;
    } wdt_cnt_state_t;

    wdt_cnt_state_t     s;
    wdt_cnt_state_t     next_s;
    logic [3:0]         sel;
    logic [4:0]         shift;
    logic [COUNT_W-1:0] terminal;

    // reserved codes fall back to the longest period rather than wrapping short
    assign sel      = (period_select > wdt_pkg::PERIOD_MAX_SEL) ? wdt_pkg::PERIOD_MAX_SEL
                                                                : period_select;
    assign shift    = wdt_pkg::PERIOD_BASE_LOG2 + {1'b0, sel};
    assign terminal = (COUNT_W'(1) << shift) - COUNT_W'(1);

    always_comb begin
        next_s         = s;
        next_s.timeout = 1'b0;
        if (restart || !run) begin
            next_s.count = '0;
        end else if (tick) begin
            if (s.count >= terminal) begin
                next_s.count   = '0;
                next_s.timeout = 1'b1;
            end else begin
                next_s.count = s.count + COUNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign timeout = s.timeout;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_restart_clears: assert property (restart |=> s.count == '0 && !timeout)
        else $error("restart did not clear the counter");
    a_timeout_terminal: assert property (
        tick && run && !restart && s.count == terminal |=> timeout)
        else $error("terminal count reached without time-out");
    a_no_early_timeout: assert property (
        tick && run && !restart && s.count < terminal |=> !timeout)
        else $error("time-out before terminal count");

endmodule

`default_nettype wire

/* File: rtl/wdt_top.sv */
// watchdog timer with control register and reset-cause register on apb
// assumes presetn is the power-on reset and the core supplies restart,
// interrupt-vector acknowledge and the global interrupt enable as pulses/levels
`default_nettype none

module wdt_top (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      wdt_osc_in,
    input  wire logic                      always_on_fuse,
    input  wire logic                      global_int_enable,
    input  wire logic                      wdt_restart,
    input  wire logic                      irq_vector_ack,
    input  wire wdt_pkg::wdt_reset_events_t reset_events,
    output logic                           wdt_irq,
    output logic                           wdt_system_reset
);

    wdt_pkg::wdt_state_t s;
    wdt_pkg::wdt_state_t next_s;
    wdt_pkg::wdt_mode_t  mode;

    logic       osc_rise;
    logic       timeout;
    logic       fuse_programmed;
    logic       reset_enable_eff;
    logic       int_enable_eff;
    logic       window_open;
    logic       hit_ctrl;
    logic       hit_cause;
    logic       wr_ctrl;
    logic       wr_cause;
    logic       rd_setup;
    logic       sys_reset_event;
    logic       counter_restart;
    logic [7:0] wbyte;
    logic [7:0] ctrl_view;
    logic [7:0] cause_view;

    // ------------------------------------------------------------
    // oscillator edge and period counter
    // ------------------------------------------------------------
    wdt_osc_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .osc_in   (wdt_osc_in),
        .osc_rise (osc_rise)
    );

    wdt_counter #(
        .COUNT_W (wdt_pkg::COUNT_W)
    ) u_counter (
        .pclk          (pclk),
        .presetn       (presetn),
        .tick          (osc_rise),
        .run           (mode != wdt_pkg::WDT_STOPPED),
        .restart       (counter_restart),
        .period_select (s.timeout_period_select),
        .timeout       (timeout)
    );

    // ------------------------------------------------------------
    // effective mode
    // ------------------------------------------------------------
    assign fuse_programmed  = ~always_on_fuse;
    assign reset_enable_eff = fuse_programmed | s.timeout_reset_enable
                            | s.watchdog_reset_cause_flag;
    assign int_enable_eff   = ~fuse_programmed & s.timeout_interrupt_enable;
    assign window_open      = (s.window_count != 3'h0);

    always_comb begin
        unique case ({reset_enable_eff, int_enable_eff})
            2'b00:   mode = wdt_pkg::WDT_STOPPED;
            2'b01:   mode = wdt_pkg::WDT_INT;
            2'b10:   mode = wdt_pkg::WDT_RST;
            2'b11:   mode = wdt_pkg::WDT_INT_RST;
        endcase
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign hit_ctrl  = (paddr == wdt_pkg::CTRL_ADDR);
    assign hit_cause = (paddr == wdt_pkg::CAUSE_ADDR);
    assign wr_ctrl   = psel & penable & pwrite & hit_ctrl;
    assign wr_cause  = psel & penable & pwrite & hit_cause;
    assign rd_setup  = psel & ~penable & ~pwrite;
    assign wbyte     = pwdata[7:0];

    assign ctrl_view  = {s.timeout_interrupt_flag, int_enable_eff,
                         s.timeout_period_select[3], window_open, reset_enable_eff,
                         s.timeout_period_select[2:0]};
    assign cause_view = {4'h0, s.watchdog_reset_cause_flag, s.brownout_cause_flag,
                         s.external_pin_cause_flag, s.power_on_cause_flag};

    // any system reset other than power-on restarts the watchdog and its setup
    assign sys_reset_event = s.sys_reset_pulse | reset_events.brownout
                           | reset_events.external_pin;
    assign counter_restart = wdt_restart | sys_reset_event;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s                 = s;
        next_s.sys_reset_pulse = 1'b0;
        if (window_open) begin
            next_s.window_count = s.window_count - 3'h1;
        end

        if (rd_setup) begin
            next_s.rdata = hit_cause ? cause_view : (hit_ctrl ? ctrl_view : 8'h00);
        end

        if (wr_ctrl) begin
            if (wbyte[wdt_pkg::CTRL_IF_BIT]) begin
                next_s.timeout_interrupt_flag = 1'b0;
            end
            next_s.timeout_interrupt_enable = wbyte[wdt_pkg::CTRL_IE_BIT];
            if (wbyte[wdt_pkg::CTRL_CE_BIT] && wbyte[wdt_pkg::CTRL_RE_BIT]) begin
                next_s.window_count         = wdt_pkg::CHANGE_WINDOW_CYCLES;
                next_s.timeout_reset_enable = 1'b1;
            end else if (window_open && !wbyte[wdt_pkg::CTRL_CE_BIT]) begin
                next_s.timeout_reset_enable  = wbyte[wdt_pkg::CTRL_RE_BIT];
                next_s.timeout_period_select = {wbyte[wdt_pkg::CTRL_P3_BIT],
                                                wbyte[wdt_pkg::CTRL_P2_BIT:0]};
                next_s.window_count          = 3'h0;
            end else begin
                // outside the window reset enable can only be raised
                next_s.timeout_reset_enable = s.timeout_reset_enable
                                            | wbyte[wdt_pkg::CTRL_RE_BIT];
            end
        end

        if (wr_cause) begin
            next_s.watchdog_reset_cause_flag = s.watchdog_reset_cause_flag
                                             & wbyte[wdt_pkg::CAUSE_WD_BIT];
            next_s.brownout_cause_flag       = s.brownout_cause_flag
                                             & wbyte[wdt_pkg::CAUSE_BO_BIT];
            next_s.external_pin_cause_flag   = s.external_pin_cause_flag
                                             & wbyte[wdt_pkg::CAUSE_EX_BIT];
            next_s.power_on_cause_flag       = s.power_on_cause_flag
                                             & wbyte[wdt_pkg::CAUSE_PO_BIT];
        end

        if (irq_vector_ack) begin
            next_s.timeout_interrupt_flag = 1'b0;
            if (mode == wdt_pkg::WDT_INT_RST) begin
                next_s.timeout_interrupt_enable = 1'b0;
            end
        end

        // time-out placed after the clears so that a set wins
        if (timeout) begin
            unique case (mode)
                wdt_pkg::WDT_STOPPED: begin
                end
                wdt_pkg::WDT_INT: begin
                    next_s.timeout_interrupt_flag = 1'b1;
                end
                wdt_pkg::WDT_RST: begin
                    next_s.sys_reset_pulse = 1'b1;
                end
                wdt_pkg::WDT_INT_RST: begin
                    if (s.timeout_interrupt_flag) begin
                        next_s.sys_reset_pulse = 1'b1;
                    end else begin
                        next_s.timeout_interrupt_flag = 1'b1;
                    end
                end
            endcase
        end

        // a system reset returns the control bits to their initial values;
        // reset enable survives so the cause flag can keep it forced
        if (sys_reset_event) begin
            next_s.timeout_interrupt_flag   = 1'b0;
            next_s.timeout_interrupt_enable = 1'b0;
            next_s.timeout_period_select    = wdt_pkg::PERIOD_RESET;
            next_s.window_count             = 3'h0;
            next_s.sys_reset_pulse          = 1'b0;
        end
        if (s.sys_reset_pulse) begin
            next_s.watchdog_reset_cause_flag = 1'b1;
        end
        if (reset_events.brownout) begin
            next_s.brownout_cause_flag = 1'b1;
        end
        if (reset_events.external_pin) begin
            next_s.external_pin_cause_flag = 1'b1;
        end
    end

    // power-on reset clears every flag except the power-on flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                     <= '0;
            s.power_on_cause_flag <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata           = {24'h000000, s.rdata};
    assign pready           = 1'b1;
    assign pslverr          = psel & penable & ~(hit_ctrl | hit_cause);
    assign wdt_irq          = s.timeout_interrupt_flag & int_enable_eff
                            & global_int_enable;
    assign wdt_system_reset = s.sys_reset_pulse;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_open_write;
        wr_ctrl && wbyte[wdt_pkg::CTRL_CE_BIT] && wbyte[wdt_pkg::CTRL_RE_BIT]
            && !sys_reset_event;
    endsequence

    sequence s_window_runs;
        window_open[*4] ##1 !window_open;
    endsequence

    a_window_opens: assert property (s_open_write |=> s.window_count == 3'h4)
        else $error("change window not loaded to four");
    a_window_closes: assert property (
        s_open_write ##1 (!wr_ctrl && !sys_reset_event)[*4] |=> !window_open)
        else $error("change window still open after four cycles");
    a_window_span: assert property (
        s_open_write ##1 (!wr_ctrl && !sys_reset_event)[*3] |-> window_open)
        else $error("change window closed early");
    a_period_locked: assert property (
        wr_ctrl && !window_open && !sys_reset_event |=> $stable(s.timeout_period_select))
        else $error("period changed outside change window");
    a_reset_single: assert property (wdt_system_reset |=> !wdt_system_reset)
        else $error("system reset pulse longer than one cycle");
    a_reset_sets_cause: assert property (
        wdt_system_reset |=> s.watchdog_reset_cause_flag && reset_enable_eff)
        else $error("watchdog reset did not set its cause flag");
    a_fuse_forces_reset: assert property (
        timeout && fuse_programmed && !sys_reset_event |=> wdt_system_reset)
        else $error("programmed fuse time-out did not reset");
    a_int_mode_flag: assert property (
        timeout && mode == wdt_pkg::WDT_INT && !sys_reset_event
            |=> s.timeout_interrupt_flag && !wdt_system_reset)
        else $error("interrupt-mode time-out misbehaved");
    a_combined_second: assert property (
        timeout && mode == wdt_pkg::WDT_INT_RST && s.timeout_interrupt_flag
            && !sys_reset_event |=> wdt_system_reset)
        else $error("unserved combined time-out did not reset");
    a_ack_to_reset_mode: assert property (
        irq_vector_ack && mode == wdt_pkg::WDT_INT_RST && !timeout && !sys_reset_event
            |=> !s.timeout_interrupt_enable && !s.timeout_interrupt_flag)
        else $error("vector did not drop combined mode to reset mode");
    a_irq_gated: assert property (
        wdt_irq |-> global_int_enable && s.timeout_interrupt_enable)
        else $error("interrupt raised without both enables");
    a_cause_upper_zero: assert property (
        rd_setup && hit_cause |=> prdata[7:4] == 4'h0)
        else $error("reserved cause bits read non-zero");
    a_cause_forces_re: assert property (
        rd_setup && hit_ctrl && s.watchdog_reset_cause_flag |=> prdata[3])
        else $error("reset enable read clear while cause flag set");
    a_por_held: assert property (
        s.power_on_cause_flag && !wr_cause |=> s.power_on_cause_flag)
        else $error("power-on flag lost without a write");

endmodule

`default_nettype wire

/* File: verif/wdt_tb.sv */
// self-checking bench for the watchdog and reset-cause block
// assumes rtl/ is compiled first; the bench drives every port itself
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals and instance
    // ----------------------------------------------------------------
    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]                paddr;
    logic [31:0]                pwdata, prdata, rd;
    logic                       wdt_osc_in, always_on_fuse, global_int_enable;
    logic                       wdt_restart, irq_vector_ack, wdt_irq, wdt_system_reset;
    wdt_pkg::wdt_reset_events_t reset_events;
    wire logic [11:0]           ctl = wdt_pkg::CTRL_ADDR;
    wire logic [11:0]           cau = wdt_pkg::CAUSE_ADDR;
    int                         n_fail, n_compared;

    wdt_top u_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_osc_in(wdt_osc_in), .always_on_fuse(always_on_fuse),
        .global_int_enable(global_int_enable), .wdt_restart(wdt_restart),
        .irq_vector_ack(irq_vector_ack), .reset_events(reset_events),
        .wdt_irq(wdt_irq), .wdt_system_reset(wdt_system_reset));

    // ----------------------------------------------------------------
    // clock, oscillator and watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // fast oscillator keeps the shortest period near 16k pclk cycles
    initial begin
        wdt_osc_in = 1'b0;
        forever begin
            repeat (4) @(posedge pclk);
            wdt_osc_in <= ~wdt_osc_in;
        end
    end

    initial begin
        #1700000;
        n_fail++;
        results();
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // setup then access; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0) wdt_restart <= 1'b1;
        else irq_vector_ack <= 1'b1;
        @(posedge pclk);
        wdt_restart <= 1'b0;
        irq_vector_ack <= 1'b0;
    endtask

    task automatic ev(input logic [1:0] e);
        @(posedge pclk);
        reset_events <= e;
        @(posedge pclk);
        reset_events <= 2'b00;
    endtask

    task automatic wait_high(input logic sel_rst);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(posedge pclk);
            if ((sel_rst ? wdt_system_reset : wdt_irq) === 1'b1) break;
        end
        chk({31'h0, i < 20000}, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_causes;
        rdc(ctl, 32'h00);
        rdc(cau, 32'h01);
        ev(2'b10);
        rdc(cau, 32'h05);
        ev(2'b01);
        rdc(cau, 32'h07);
        apb(1'b1, cau, 8'hF0);
        rdc(cau, 32'h00);
        apb(1'b0, 12'h068, 8'h00);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask

    task automatic t_window;
        apb(1'b1, ctl, 8'h18);
        rdc(ctl, 32'h18);
        repeat (4) @(posedge pclk);
        rdc(ctl, 32'h08);
        apb(1'b1, ctl, 8'h00);
        rdc(ctl, 32'h08);
        pulse(0);
        apb(1'b1, ctl, 8'h18);
        apb(1'b1, ctl, 8'h05);
        rdc(ctl, 32'h05);
        apb(1'b1, ctl, 8'h18);
        apb(1'b1, ctl, 8'h00);
        rdc(ctl, 32'h00);
    endtask

    task automatic t_interrupt;
        pulse(0);
        apb(1'b1, ctl, 8'h40);
        wait_high(1'b0);
        rdc(ctl, 32'hC0);
        @(posedge pclk);
        global_int_enable <= 1'b0;
        @(posedge pclk);
        chk({31'h0, wdt_irq}, 32'h0);
        global_int_enable <= 1'b1;
        apb(1'b1, ctl, 8'hC0);
        rdc(ctl, 32'h40);
    endtask

    task automatic t_combined;
        pulse(0);
        apb(1'b1, ctl, 8'h48);
        wait_high(1'b0);
        rdc(ctl, 32'hC8);
        pulse(1);
        rdc(ctl, 32'h08);
        apb(1'b1, ctl, 8'h48);
        wait_high(1'b0);
        wait_high(1'b1);
        @(posedge pclk);
        chk({31'h0, wdt_system_reset}, 32'h0);
        rdc(cau, 32'h08);
        rdc(ctl, 32'h08);
        apb(1'b1, ctl, 8'h18);
        apb(1'b1, ctl, 8'h00);
        rdc(ctl, 32'h08);
        apb(1'b1, cau, 8'h00);
        apb(1'b1, ctl, 8'h18);
        apb(1'b1, ctl, 8'h00);
        rdc(ctl, 32'h00);
    endtask

    task automatic t_fuse;
        @(posedge pclk);
        always_on_fuse <= 1'b0;
        apb(1'b1, ctl, 8'h40);
        rdc(ctl, 32'h08);
    endtask

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        n_fail = 0;
        n_compared = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {wdt_restart, irq_vector_ack, reset_events} = '0;
        always_on_fuse = 1'b1;
        global_int_enable = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_causes();
        t_window();
        t_interrupt();
        t_combined();
        t_fuse();
        results();
    end
endmodule

`default_nettype wire
